// File: design/gcd_pkg.sv
// constants and types shared by the glyph-lcd command decoder files
// assumes a single 100 MHz clock domain and a synchronous active-low reset
`default_nettype none
package gcd_pkg;
  // ==========================================================================
  // command codes (exact matches)
  localparam logic [7:0] CMD_CURSOR    = 8'h21;  // load cursor pointer
  localparam logic [7:0] CMD_OFFSET    = 8'h22;  // load glyph offset
  localparam logic [7:0] CMD_ADDR      = 8'h24;  // load memory address pointer
  localparam logic [7:0] CMD_TXT_HOME  = 8'h40;  // text home address
  localparam logic [7:0] CMD_TXT_COLS  = 8'h41;  // text column count
  localparam logic [7:0] CMD_GFX_HOME  = 8'h42;  // graphic home address
  localparam logic [7:0] CMD_GFX_COLS  = 8'h43;  // graphic column count
  localparam logic [7:0] CMD_AUTO_WR   = 8'hb0;  // enter auto write
  localparam logic [7:0] CMD_AUTO_RD   = 8'hb1;  // enter auto read
  localparam logic [7:0] CMD_AUTO_END  = 8'hb2;  // leave auto mode
  // ==========================================================================
  // command group prefixes and field widths
  localparam logic [3:0] GRP_MODE      = 4'h8;   // 1000xxxx mode set
  localparam logic [3:0] GRP_DISP      = 4'h9;   // 1001xxxx display mode
  localparam logic [3:0] GRP_BIT       = 4'hf;   // 1111sbbb bit set/reset
  localparam logic [4:0] GRP_CURPAT    = 5'h14;  // 10100nnn cursor pattern
  localparam logic [4:0] GRP_DATA      = 5'h18;  // 11000xxx single transfer
  localparam logic [1:0] DIR_INC       = 2'h0;   // pointer step: increment
  localparam logic [1:0] DIR_DEC       = 2'h1;   // pointer step: decrement
  localparam int         COL_BITS      = 7;      // cursor column bits used
  localparam int         ROW_BITS      = 5;      // cursor row bits used
  localparam int         OFS_BITS      = 5;      // glyph offset bits
  localparam int         GROW_BITS     = 3;      // glyph row index bits
  // ==========================================================================
  // status word bit positions
  localparam int         ST_CMD_RDY    = 0;      // command_ready_flag
  localparam int         ST_DAT_RDY    = 1;      // data_ready_flag
  localparam int         ST_AUTO_RD    = 2;      // auto read ready
  localparam int         ST_AUTO_WR    = 3;      // auto write ready
  // ==========================================================================
  // memory access sequencer
  typedef enum logic [1:0] {
    GCD_IDLE,
    GCD_RD_REQ,
    GCD_RD_CAP
  } gcd_state_t;
endpackage
`default_nettype wire

// File: design/gcd_glyph_if.sv
// carrier between the decoder top and the glyph address former
// assumes both ends sit in the same clock domain
`default_nettype none
interface gcd_glyph_if;
  logic [4:0]  offset;  // glyph offset register
  logic [7:0]  code;    // character code
  logic [2:0]  row;     // glyph row index
  logic        ext;     // external glyph memory selected
  logic [15:0] addr;    // formed glyph memory address
  logic        user;    // glyph comes from user glyph memory
  modport src    (output offset, code, row, ext, input addr, user);
  modport former (input offset, code, row, ext, output addr, user);
endinterface
`default_nettype wire

// File: design/gcd_glyph_addr.sv
// glyph memory address former: purely combinational
// assumes the caller registers the results
`default_nettype none
module gcd_glyph_addr
(
  // glyph request and result
  gcd_glyph_if.former g
);
  // ==========================================================================
  // address layout
  // offset over code over row
  // each offset picks a 2-Kbyte block
  assign g.addr = {g.offset, g.code, g.row};
  // rom serves low half, user memory high half; with ext set, user memory serves all
  assign g.user = g.ext | g.code[7];
endmodule
`default_nettype wire

// File: design/gcd_top.sv
// command decoder of a graphic lcd controller: host byte port, display
// memory port and the decoded display configuration as plain outputs
// assumes host strobes are one-cycle pulses synchronous to i_clk and that
// i_mem_rdata is valid in the cycle after o_mem_re is high
`default_nettype none
// What this block does
// - command 21h loads cursor column then row
// - only that command moves the cursor
// - column uses low seven bits
// - row uses low five bits
// - command 22h loads glyph offset
// - command 24h loads pointer low then high
// - 40h-43h load home addresses and columns
// - glyph address is offset, code, row
// - rom mode: high codes use user memory
// - external mode: all codes use user memory
// - offset selects a 2-Kbyte glyph block
// - mode set picks combine and source
// - display mode sets four enables
// - c0h-c5h single access, step pointer (c4h/c5h hold it)
// - 1111sbbb sets or clears one bit
module gcd_top
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // host byte port (i_cd high: command/status, low: data)
  input  wire logic        i_cd,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_din,
  output var  logic [7:0]  o_rd_data,
  output var  logic        o_rd_valid,
  output var  logic [7:0]  o_status,
  // display memory port
  output var  logic [15:0] o_mem_addr,
  output var  logic [7:0]  o_mem_wdata,
  output var  logic        o_mem_we,
  output var  logic        o_mem_re,
  input  wire logic [7:0]  i_mem_rdata,
  // glyph lookup
  input  wire logic [7:0]  i_glyph_code,
  input  wire logic [2:0]  i_glyph_row,
  output var  logic [15:0] o_glyph_addr,
  output var  logic        o_glyph_user,
  // decoded configuration
  output var  logic [6:0]  o_cursor_col,
  output var  logic [4:0]  o_cursor_row,
  output var  logic [4:0]  o_offset,
  output var  logic [15:0] o_text_home,
  output var  logic [7:0]  o_text_cols,
  output var  logic [15:0] o_gfx_home,
  output var  logic [7:0]  o_gfx_cols,
  output var  logic [2:0]  o_combine_mode,
  output var  logic        o_ext_glyph,
  output var  logic        o_gfx_en,
  output var  logic        o_text_en,
  output var  logic        o_cursor_en,
  output var  logic        o_blink_en,
  output var  logic [2:0]  o_cursor_lines
);
  // ==========================================================================
  // state
  gcd_pkg::gcd_state_t st_q;      // access sequencer
  logic [7:0]  par_old_q;         // first parameter (D1 of two)
  logic [7:0]  par_new_q;         // latest parameter (D2, or D1 of one)
  logic [15:0] ptr_q;             // memory_address_pointer
  logic        auto_wr_q;         // auto write mode
  logic        auto_rd_q;         // auto read mode
  logic        rmw_q;             // current read is a bit modify
  logic        bit_val_q;         // bit value to write back
  logic [2:0]  bit_num_q;         // bit number to modify
  gcd_glyph_if gif ();            // link to address former

  // ==========================================================================
  // host strobe decode
  wire idle     = (st_q == gcd_pkg::GCD_IDLE);
  wire in_auto  = auto_wr_q | auto_rd_q;
  wire cmd_wr   = i_wr & i_cd & idle;
  wire dat_wr   = i_wr & ~i_cd & idle;
  wire dat_rd   = i_rd & ~i_cd & idle;
  wire [7:0] c  = i_din;
  // in auto mode only the leave command is honoured
  wire cmd_ok   = cmd_wr & ~in_auto;
  // only the defining bits are compared
  wire is_cur   = cmd_ok & (c == gcd_pkg::CMD_CURSOR);
  wire is_ofs   = cmd_ok & (c == gcd_pkg::CMD_OFFSET);
  wire is_adr   = cmd_ok & (c == gcd_pkg::CMD_ADDR);
  wire is_thome = cmd_ok & (c == gcd_pkg::CMD_TXT_HOME);
  wire is_tcols = cmd_ok & (c == gcd_pkg::CMD_TXT_COLS);
  wire is_ghome = cmd_ok & (c == gcd_pkg::CMD_GFX_HOME);
  wire is_gcols = cmd_ok & (c == gcd_pkg::CMD_GFX_COLS);
  wire is_mode  = cmd_ok & (c[7:4] == gcd_pkg::GRP_MODE);
  wire is_disp  = cmd_ok & (c[7:4] == gcd_pkg::GRP_DISP);
  wire is_cpat  = cmd_ok & (c[7:3] == gcd_pkg::GRP_CURPAT);
  wire is_awr   = cmd_ok & (c == gcd_pkg::CMD_AUTO_WR);
  wire is_ard   = cmd_ok & (c == gcd_pkg::CMD_AUTO_RD);
  wire is_aend  = cmd_wr & (c == gcd_pkg::CMD_AUTO_END);
  wire is_data  = cmd_ok & (c[7:3] == gcd_pkg::GRP_DATA) & (c[2:1] != 2'h3);
  wire is_bit   = cmd_ok & (c[7:4] == gcd_pkg::GRP_BIT);
  // single transfer split by direction bit
  wire one_wr   = is_data & ~c[0];
  wire one_rd   = is_data & c[0];
  // auto transfers ride on data strobes
  wire auto_w   = dat_wr & auto_wr_q;
  wire auto_r   = dat_rd & auto_rd_q;
  wire plain_p  = dat_wr & ~in_auto;
  // pointer step: single access by bits 2:1, auto always increments
  wire [15:0] ptr_inc = ptr_q + 16'h0001;
  wire [15:0] ptr_dec = ptr_q - 16'h0001;
  wire [15:0] ptr_step = (c[2:1] == gcd_pkg::DIR_INC) ? ptr_inc :
                         (c[2:1] == gcd_pkg::DIR_DEC) ? ptr_dec : ptr_q;
  wire mem_rd_go = one_rd | auto_r | is_bit;
  wire mem_wr_go = one_wr | auto_w;
  // read-modify-write byte built from fetched data
  wire [7:0] bit_mask = 8'h01 << bit_num_q;
  wire [7:0] rmw_byte = bit_val_q ? (i_mem_rdata | bit_mask) : (i_mem_rdata & ~bit_mask);
  // status flags drop while the sequencer is busy
  wire [7:0] status_d = {4'h0, auto_wr_q & idle, auto_rd_q & idle,
                         idle & ~in_auto, idle & ~in_auto};

  // ==========================================================================
  // glyph address former
  assign gif.offset = o_offset;
  assign gif.code   = i_glyph_code;
  assign gif.row    = i_glyph_row;
  assign gif.ext    = o_ext_glyph;
  gcd_glyph_addr u_glyph (.g(gif.former));

  // ==========================================================================
  // parameter capture: newest two bytes count, older ones fall out
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      par_old_q <= 8'h00;
      par_new_q <= 8'h00;
    end
    else if (plain_p)
    begin
      par_old_q <= par_new_q;
      par_new_q <= i_din;
    end
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_cursor_col   <= 7'h00;
      o_cursor_row   <= 5'h00;
      o_offset       <= 5'h00;
      o_text_home    <= 16'h0000;
      o_text_cols    <= 8'h00;
      o_gfx_home     <= 16'h0000;
      o_gfx_cols     <= 8'h00;
      o_combine_mode <= 3'h0;
      o_ext_glyph    <= 1'b0;
      {o_gfx_en, o_text_en, o_cursor_en, o_blink_en} <= 4'h0;
      o_cursor_lines <= 3'h0;
    end
    else
    begin
      if (is_cur)
      begin
        o_cursor_col <= par_old_q[gcd_pkg::COL_BITS-1:0];
        o_cursor_row <= par_new_q[gcd_pkg::ROW_BITS-1:0];
      end
      // second byte is a fixed zero
      if (is_ofs)
        o_offset <= par_old_q[gcd_pkg::OFS_BITS-1:0];
      // homes low/high, columns from first byte
      if (is_thome)
        o_text_home <= {par_new_q, par_old_q};
      if (is_tcols)
        o_text_cols <= par_old_q;
      if (is_ghome)
        o_gfx_home <= {par_new_q, par_old_q};
      if (is_gcols)
        o_gfx_cols <= par_old_q;
      if (is_mode)
      begin
        o_combine_mode <= c[2:0];
        o_ext_glyph    <= c[3];
      end
      if (is_disp)
        {o_gfx_en, o_text_en, o_cursor_en, o_blink_en} <= c[3:0];
      // height stored as lines minus one
      if (is_cpat)
        o_cursor_lines <= c[2:0];
    end
  end

  // ==========================================================================
  // address pointer, auto modes and memory sequencer
  // cursor untouched here, only by its own command
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_q        <= gcd_pkg::GCD_IDLE;
      ptr_q       <= 16'h0000;
      auto_wr_q   <= 1'b0;
      auto_rd_q   <= 1'b0;
      rmw_q       <= 1'b0;
      bit_val_q   <= 1'b0;
      bit_num_q   <= 3'h0;
      o_mem_addr  <= 16'h0000;
      o_mem_wdata <= 8'h00;
      o_mem_we    <= 1'b0;
      o_mem_re    <= 1'b0;
      o_rd_data   <= 8'h00;
      o_rd_valid  <= 1'b0;
    end
    else
    begin
      o_mem_we   <= 1'b0;
      o_mem_re   <= 1'b0;
      o_rd_valid <= 1'b0;
      if (is_adr)
        ptr_q <= {par_new_q, par_old_q};
      if (is_awr)
        auto_wr_q <= 1'b1;
      if (is_ard)
        auto_rd_q <= 1'b1;
      if (is_aend)
      begin
        auto_wr_q <= 1'b0;
        auto_rd_q <= 1'b0;
      end
      unique case (st_q)
        gcd_pkg::GCD_IDLE:
        begin
          if (mem_wr_go)
          begin
            o_mem_addr  <= ptr_q;
            o_mem_wdata <= auto_w ? i_din : par_new_q;
            o_mem_we    <= 1'b1;
            ptr_q       <= auto_w ? ptr_inc : ptr_step;
          end
          else if (mem_rd_go)
          begin
            o_mem_addr <= ptr_q;
            o_mem_re   <= 1'b1;
            rmw_q      <= is_bit;
            bit_val_q  <= c[3];
            bit_num_q  <= c[2:0];
            st_q       <= gcd_pkg::GCD_RD_REQ;
            if (one_rd)
              ptr_q <= ptr_step;
            else if (auto_r)
              ptr_q <= ptr_inc;
          end
        end
        gcd_pkg::GCD_RD_REQ:
          st_q <= gcd_pkg::GCD_RD_CAP;
        gcd_pkg::GCD_RD_CAP:
        begin
          st_q <= gcd_pkg::GCD_IDLE;
          // write back with one bit changed
          if (rmw_q)
          begin
            o_mem_wdata <= rmw_byte;
            o_mem_we    <= 1'b1;
          end
          else
          begin
            o_rd_data  <= i_mem_rdata;
            o_rd_valid <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // registered status and glyph result
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_status     <= 8'h00;
      o_glyph_addr <= 16'h0000;
      o_glyph_user <= 1'b0;
    end
    else
    begin
      o_status     <= status_d;
      o_glyph_addr <= gif.addr;
      o_glyph_user <= gif.user;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_cmd;
    one_rd | auto_r;
  endsequence
  sequence s_rd_done;
    o_mem_re ##2 o_rd_valid;
  endsequence
  cursor_load_a: assert property (is_cur |=> o_cursor_col == $past(par_old_q[6:0]) && o_cursor_row == $past(par_new_q[4:0]))
    else $error("cursor not loaded from parameters");
  cursor_hold_a: assert property ((dat_wr | dat_rd | is_data) |=> $stable(o_cursor_col) && $stable(o_cursor_row))
    else $error("cursor moved by data transfer");
  offset_load_a: assert property (is_ofs |=> o_offset == $past(par_old_q[4:0]))
    else $error("offset not loaded");
  // pointer takes low then high parameter byte
  ptr_load_a: assert property (is_adr |=> ptr_q == $past({par_new_q, par_old_q}))
    else $error("pointer load wrong");
  glyph_addr_a: assert property (##1 o_glyph_addr == {$past(o_offset), $past(i_glyph_code), $past(i_glyph_row)})
    else $error("glyph address layout wrong");
  glyph_src_a: assert property (##1 o_glyph_user == ($past(o_ext_glyph) || $past(i_glyph_code) >= 8'h80))
    else $error("glyph source select wrong");
  // read answers two cycles after request
  read_seq_a: assert property (s_rd_cmd |=> s_rd_done)
    else $error("read data not returned");
  // bit modify write lands three cycles later
  bit_rmw_a: assert property (is_bit |-> ##3 (o_mem_we && o_mem_wdata[$past(c[2:0], 3)] == $past(c[3], 3)))
    else $error("bit modify wrong");
  cursor_pat_a: assert property (is_cpat |=> o_cursor_lines == $past(c[2:0]))
    else $error("cursor height wrong");
  // auto write is set the cycle after its command
  auto_mode_a: assert property (is_awr |=> auto_wr_q)
    else $error("auto write not entered");
endmodule
`default_nettype wire

// File: test/gcd_mem_model.sv
// display memory model on the far side of the decoder's memory port
// assumes one-cycle write and read pulses from the decoder, same clock
`default_nettype none
module gcd_mem_model
(
  // clock
  input  wire logic        i_clk,
  // memory request
  input  wire logic [15:0] i_mem_addr,
  input  wire logic [7:0]  i_mem_wdata,
  input  wire logic        i_mem_we,
  input  wire logic        i_mem_re,
  // read answer
  output var  logic [7:0]  o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // storage: low address byte only, enough for the tests
  logic [7:0] mem [0:255];
  initial o_mem_rdata = 8'h00;
  // answer valid only in the cycle after a read pulse; otherwise the
  // bus toggles so a byte sampled one cycle late cannot pass as a fresh one
  always @(posedge i_clk)
  begin
    if (i_mem_we)
      mem[i_mem_addr[7:0]] <= i_mem_wdata;
    if (i_mem_re)
      o_mem_rdata <= mem[i_mem_addr[7:0]];
    else
      o_mem_rdata <= ~o_mem_rdata;
  end
endmodule
`default_nettype wire

// File: test/gcd_top_tb.sv
// self-checking bench for the command decoder, acting as host
// assumes the display memory model answers one cycle after a read pulse
`default_nettype none
module gcd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_cd = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_din = 8'h00, i_glyph_code = 8'h00, o_rd_data, o_status, o_mem_wdata, i_mem_rdata;
  logic [2:0] i_glyph_row = 3'h0, o_combine_mode, o_cursor_lines;
  logic o_rd_valid, o_mem_we, o_mem_re, o_glyph_user, o_ext_glyph, o_gfx_en, o_text_en, o_cursor_en, o_blink_en;
  logic [15:0] o_mem_addr, o_glyph_addr, o_text_home, o_gfx_home;
  logic [6:0] o_cursor_col;
  logic [4:0] o_cursor_row, o_offset;
  logic [7:0] o_text_cols, o_gfx_cols;
  int errors = 0, checked = 0;
  logic [7:0] rmask = 8'h03;  // status bits the host waits for
  logic [7:0] bexp;           // expected byte after bit commands
  logic [7:0] ops [6] = '{8'hc0, 8'hc2, 8'hc4, 8'hc5, 8'hc1, 8'hc3};
  logic [7:0] dat [6] = '{8'haa, 8'hbb, 8'hcc, 8'hcc, 8'hcc, 8'hbb};
  logic [7:0] ea  [6] = '{8'h34, 8'h35, 8'h34, 8'h34, 8'h34, 8'h35};
  logic [7:0] bcm [4] = '{8'hf9, 8'hf2, 8'hf3, 8'hf7};
  logic [7:0] mcm [5] = '{8'h80, 8'h81, 8'h83, 8'h84, 8'h8b};
  logic [7:0] dcm [4] = '{8'h90, 8'h9f, 8'h96, 8'h99};
  // ==========================================
  // design and memory partner
  gcd_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cd(i_cd), .i_wr(i_wr), .i_rd(i_rd), .i_din(i_din),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_status(o_status), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we), .o_mem_re(o_mem_re), .i_mem_rdata(i_mem_rdata),
    .i_glyph_code(i_glyph_code), .i_glyph_row(i_glyph_row), .o_glyph_addr(o_glyph_addr),
    .o_glyph_user(o_glyph_user), .o_cursor_col(o_cursor_col), .o_cursor_row(o_cursor_row),
    .o_offset(o_offset), .o_text_home(o_text_home), .o_text_cols(o_text_cols), .o_gfx_home(o_gfx_home),
    .o_gfx_cols(o_gfx_cols), .o_combine_mode(o_combine_mode), .o_ext_glyph(o_ext_glyph),
    .o_gfx_en(o_gfx_en), .o_text_en(o_text_en), .o_cursor_en(o_cursor_en), .o_blink_en(o_blink_en),
    .o_cursor_lines(o_cursor_lines));
  gcd_mem_model mem (.i_clk(i_clk), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
    .i_mem_we(o_mem_we), .i_mem_re(o_mem_re), .o_mem_rdata(i_mem_rdata));
  // ==========================================
  // clock, 10 ns period
  initial forever #5 i_clk = ~i_clk;
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // host polls status before every transfer; status lags one cycle
  task automatic pulse(input logic cd, input logic wr, input logic [7:0] b);
    for (int k = 0; k < 20; k++)
    begin
      @(negedge i_clk);
      if ((o_status & rmask) === rmask && k > 0)
        break;
    end
    // a poll that runs out counts as a mismatch
    chk(o_status & rmask, rmask);
    i_cd = cd; i_wr = wr; i_rd = ~wr; i_din = b;
    @(negedge i_clk);
    i_wr = 1'b0; i_rd = 1'b0;
  endtask
  task automatic wr_data(input logic [7:0] b); pulse(1'b0, 1'b1, b); endtask
  task automatic wr_cmd(input logic [7:0] c); pulse(1'b1, 1'b1, c); endtask
  task automatic rd_data(); pulse(1'b0, 1'b0, 8'h00); endtask
  // parameters always go first, command byte last
  task automatic cmd2(input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] c);
    wr_data(d1); wr_data(d2); wr_cmd(c);
  endtask
  // bounded wait for a write pulse (we=1) or read-valid pulse (we=0)
  task automatic wait_hi(input bit we);
    for (int k = 0; k < 8; k++)
    begin
      if ((we ? o_mem_we : o_rd_valid) === 1'b1)
        break;
      @(negedge i_clk);
    end
    // a pulse that never came counts as a mismatch
    chk(we ? o_mem_we : o_rd_valid, 16'h1);
  endtask
  task automatic glyph(input logic [7:0] c, input logic [2:0] r, input logic [15:0] ea2, input logic u);
    @(negedge i_clk);
    i_glyph_code = c; i_glyph_row = r;
    @(negedge i_clk);
    chk(o_glyph_addr, ea2); chk(o_glyph_user, u);
  endtask
  task automatic end_of_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (4) @(negedge i_clk);
    chk(o_status, 16'h0); chk(o_cursor_col, 16'h0);
    i_rst_n = 1'b1;
    // column 0xcf keeps seven bits, row 0xff keeps five
    cmd2(8'hcf, 8'hff, 8'h21);
    chk({o_cursor_col, o_cursor_row}, {7'h4f, 5'h1f});
    cmd2(8'h4f, 8'h0f, 8'h21);
    cmd2(8'h02, 8'h00, 8'h22);
    chk(o_offset, 16'h2);
    glyph(8'h80, 3'h3, 16'h1403, 1'b1);
    glyph(8'h7f, 3'h0, 16'h13f8, 1'b0);
    cmd2(8'h1f, 8'h00, 8'h22);
    glyph(8'hff, 3'h7, 16'hffff, 1'b1);
    // extra leading parameter must be ignored
    wr_data(8'h77);
    cmd2(8'hcd, 8'hab, 8'h40);
    cmd2(8'h28, 8'h00, 8'h41);
    cmd2(8'h34, 8'h12, 8'h42);
    cmd2(8'h1e, 8'h00, 8'h43);
    chk(o_text_home, 16'habcd); chk(o_text_cols, 16'h28);
    chk(o_gfx_home, 16'h1234); chk(o_gfx_cols, 16'h1e);
    // single transfers: increment, decrement, hold
    cmd2(8'h34, 8'h12, 8'h24);
    for (int i = 0; i < 6; i++)
    begin
      if (!ops[i][0])
      begin
        wr_data(dat[i]);
        wr_cmd(ops[i]);
        chk(o_mem_we, 16'h1); chk(o_mem_wdata, dat[i]);
      end
      else
      begin
        wr_cmd(ops[i]);
        chk(o_mem_re, 16'h1);
      end
      chk(o_mem_addr, {8'h12, ea[i]});
      if (ops[i][0])
      begin
        wait_hi(1'b0);
        chk(o_rd_data, dat[i]);
      end
    end
    chk({o_cursor_col, o_cursor_row}, {7'h4f, 5'h0f});
    // bit set and reset on byte 0xcc at the pointer
    bexp = 8'hcc;
    foreach (bcm[i])
    begin
      wr_cmd(bcm[i]);
      bexp[bcm[i][2:0]] = bcm[i][3];
      wait_hi(1'b1);
      chk(o_mem_wdata, bexp);
      chk(o_mem_addr, 16'h1234);
    end
    foreach (mcm[i])
    begin
      wr_cmd(mcm[i]);
      chk({o_ext_glyph, o_combine_mode}, mcm[i][3:0]);
    end
    glyph(8'h05, 3'h1, 16'hf829, 1'b1);
    foreach (dcm[i])
    begin
      wr_cmd(dcm[i]);
      chk({o_gfx_en, o_text_en, o_cursor_en, o_blink_en}, dcm[i][3:0]);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr_cmd(8'ha0 + i[7:0]);
      chk(o_cursor_lines, i[15:0]);
    end
    // auto write, a foreign command ignored, then auto read back
    cmd2(8'h40, 8'h00, 8'h24);
    wr_cmd(8'hb0);
    rmask = 8'h08;
    wr_data(8'h5a);
    chk(o_mem_addr, 16'h0040); chk(o_mem_wdata, 16'h5a);
    wr_data(8'h5b);
    chk(o_mem_addr, 16'h0041); chk(o_mem_we, 16'h1);
    wr_cmd(8'h96);
    chk({o_gfx_en, o_text_en, o_cursor_en, o_blink_en}, 16'h9);
    wr_cmd(8'hb2);
    rmask = 8'h03;
    cmd2(8'h40, 8'h00, 8'h24);
    wr_cmd(8'hb1);
    rmask = 8'h04;
    rd_data();
    wait_hi(1'b0);
    chk(o_rd_data, 16'h5a);
    rd_data();
    wait_hi(1'b0);
    chk(o_rd_data, 16'h5b);
    wr_cmd(8'hb2);
    rmask = 8'h03;
    repeat (3) @(negedge i_clk);
    chk(o_status[1:0], 16'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
